// ---- src/bru_pkg.sv ----
// Constants and types shared by the branch instruction unit
package bru_pkg;
  // Instruction word layout
  localparam int INSTR_W  = 32;
  localparam int ADDR_W   = 12;
  localparam int OP_HI    = 31;
  localparam int OP_LO    = 26;
  localparam int ESS_HI   = 25;
  localparam int ESS_LO   = 22;
  localparam int POL_BIT  = 21;
  localparam int COND_BIT = 20;
  localparam int CSO_HI   = 19;
  localparam int CSO_LO   = 12;
  localparam int WADR_HI  = 11;
  localparam int WADR_LO  = 0;
  localparam int ESS_N    = 16;
  localparam int CNT_W    = 8;
  localparam int HALF_W   = 8;

  // Branch opcodes in bits 31..26
  localparam logic [5:0] OPC_IMM      = 6'h00;
  localparam logic [5:0] OPC_IMM_LINK = 6'h01;
  localparam logic [5:0] OPC_REG      = 6'h02;
  localparam logic [5:0] OPC_REG_LINK = 6'h03;
  localparam logic [5:0] OPC_SHD      = 6'h04;
  localparam logic [5:0] OPC_SHD_LINK = 6'h05;

  // Counter operation codes
  localparam logic [7:0] CSO_CODE_DEC_RXB = 8'hE0;
  localparam logic [7:0] CSO_CODE_DEC_RXF = 8'hE1;
  localparam logic [7:0] CSO_CODE_INC_TXB = 8'hC2;
  localparam logic [7:0] CSO_CODE_INC_TXF = 8'hC3;

  localparam logic [3:0]        ESS_NONE  = 4'h0;
  localparam logic [ADDR_W-1:0] LINK_STEP = 12'h002;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
  localparam logic [11:0]       LOW_ZERO  = 12'h000;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 8'hFF;
  localparam logic [CNT_W-1:0]  CNT_MIN   = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 8'h01;
  localparam logic [HALF_W-1:0] HALF_ZERO = 8'h00;

  // AHB-Lite register map (byte offsets)
  localparam int          AHB_DEC_W      = 8;
  localparam logic [7:0]  REG_LINK_OFS   = 8'h00;
  localparam logic [7:0]  REG_SHADOW_OFS = 8'h04;
  localparam logic [7:0]  REG_COUNT_OFS  = 8'h08;
  localparam logic [7:0]  REG_STATUS_OFS = 8'h0C;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
  localparam logic [1:0]  HRESP_OKAY     = 2'h0;
  localparam int          HTRANS_ACT_BIT = 1;
  localparam int          STAT_WAIT_BIT  = 0;
  localparam int          STAT_LOAD_BIT  = 1;

  typedef enum logic [1:0] {
    SRC_IMM    = 2'h0,
    SRC_LINK   = 2'h1,
    SRC_SHADOW = 2'h2
  } bru_src_type;

  typedef enum logic [2:0] {
    CSO_NONE    = 3'h0,
    CSO_DEC_RXB = 3'h1,
    CSO_DEC_RXF = 3'h2,
    CSO_INC_TXB = 3'h3,
    CSO_INC_TXF = 3'h4
  } bru_cso_type;

  // Gray path: empty -> waiting -> loaded
  typedef enum logic [1:0] {
    SHD_EMPTY  = 2'b00,
    SHD_WAIT   = 2'b01,
    SHD_LOADED = 2'b11
  } bru_shd_state_type;
endpackage

// ---- src/bru_dec_if.sv ----
// Decoded branch fields passed from the decoder to the execute logic
`timescale 1ns/100ps
interface bru_dec_if;
  import bru_pkg::*;
  logic              is_branch;
  logic              illegal;
  logic              link;
  logic              taken;
  logic              nullify;
  bru_src_type       src;
  bru_cso_type       cso;
  logic [ADDR_W-1:0] imm;

  modport producer (output is_branch, illegal, link, taken, nullify, src, cso, imm);
  modport consumer (input  is_branch, illegal, link, taken, nullify, src, cso, imm);
endinterface

// ---- src/bru_decoder.sv ----
// Branch word decoder: opcode, condition, nullify and counter operation
`timescale 1ns/100ps
module bru_decoder (
  // Instruction and state signals
  input wire logic [bru_pkg::INSTR_W-1:0] instr_word,
  input wire logic [bru_pkg::ESS_N-1:0]   ess_in,
  // Decoded fields
  bru_dec_if.producer                     dec
);
  import bru_pkg::*;

  wire logic [5:0] op_field   = instr_word[OP_HI:OP_LO];
  wire logic [3:0] ess_sel    = instr_word[ESS_HI:ESS_LO];
  wire logic       pol_bit    = instr_word[POL_BIT];
  wire logic       cond_bit   = instr_word[COND_BIT];
  wire logic [7:0] cso_field  = instr_word[CSO_HI:CSO_LO];
  wire logic [11:0] low_field = instr_word[WADR_HI:WADR_LO];

  wire logic op_imm  = (op_field == OPC_IMM)  || (op_field == OPC_IMM_LINK);
  wire logic op_reg  = (op_field == OPC_REG)  || (op_field == OPC_REG_LINK);
  wire logic op_shd  = (op_field == OPC_SHD)  || (op_field == OPC_SHD_LINK);
  wire logic is_link = (op_field == OPC_IMM_LINK) || (op_field == OPC_REG_LINK) ||
                       (op_field == OPC_SHD_LINK);
  wire logic any_op  = op_imm || op_reg || op_shd;

  // Non-immediate forms must leave the low field clear
  wire logic bad_low = !op_imm && (low_field != LOW_ZERO);

  // Selector zero means no condition; then the C bit acts as nullify
  wire logic uncond  = (ess_sel == ESS_NONE);
  wire logic cond_ok = (ess_in[ess_sel] == pol_bit);

  assign dec.is_branch = any_op && !bad_low;
  assign dec.illegal   = any_op && bad_low;
  assign dec.link      = is_link;
  assign dec.taken     = uncond || cond_ok;
  assign dec.nullify   = uncond ? cond_bit : (!cond_ok && cond_bit);
  assign dec.imm       = low_field;
  assign dec.src       = op_shd ? SRC_SHADOW : (op_reg ? SRC_LINK : SRC_IMM);

  always_comb begin
    case (cso_field)
      CSO_CODE_DEC_RXB: dec.cso = CSO_DEC_RXB;
      CSO_CODE_DEC_RXF: dec.cso = CSO_DEC_RXF;
      CSO_CODE_INC_TXB: dec.cso = CSO_INC_TXB;
      CSO_CODE_INC_TXF: dec.cso = CSO_INC_TXF;
      default:          dec.cso = CSO_NONE;
    endcase
  end
endmodule

// ---- src/bru_branch_unit.sv ----
// Branch execute unit: targets, link and shadow registers, counters, AHB-Lite slave
//
// Operation
// - Immediate branch jumps to the 12-bit word address in bits 11..0.
// - Register branch jumps to the address held in the link register.
// - Shadow branch jumps to the fast-memory shadow target register.
// - Shadow branch stalls while the shadow load from fast memory is pending.
// - Only a linked load with non-zero halfword field reloads the shadow register.
// - Once loaded, software may read and write the shadow register.
// - The first descriptor word, a service routine address, becomes the shadow target.
// - Taken linking branches save the address after the committed slot into the link register.
// - Opcode bits 31..26 select branch type; non-immediate forms need bits 11..0 zero.
// - Fields: selector 25..22, polarity 21, conditional 20, counter op 19..12.
// - Conditional branch taken only if selected state equals polarity; else unconditional.
// - Any branch may increment or decrement a cell-port handshake counter.
// - Slot nullified on failed conditional with C, or unconditional with nullify.
// - Counter operation happens whether or not the branch is taken.
// - Codes E0, E1 decrement receive counters; C2, C3 increment transmit counters.
// - Link register written only by software or when a linking branch is taken, with address plus two.
`timescale 1ns/100ps
module bru_branch_unit (
  // Clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output      logic                       hreadyout,
  output      logic [1:0]                 hresp,
  output      logic [31:0]                hrdata,
  // Pipeline instruction port
  input  wire logic                       instr_valid,
  input  wire logic [bru_pkg::INSTR_W-1:0] instr_word,
  input  wire logic [bru_pkg::ADDR_W-1:0] instr_addr,
  input  wire logic [bru_pkg::ESS_N-1:0]  ess_in,
  output      logic                       instr_stall,
  // Pipeline branch result
  output      logic                       br_valid,
  output      logic                       br_taken,
  output      logic [bru_pkg::ADDR_W-1:0] br_target,
  output      logic                       br_slot_nullify,
  output      logic                       br_illegal,
  // Fast memory side
  input  wire logic                       ldfm_valid,
  input  wire logic                       ldfm_link_option,
  input  wire logic [bru_pkg::HALF_W-1:0] ldfm_halfword,
  input  wire logic                       fm_first_valid,
  input  wire logic [31:0]                fm_first_word,
  // Cell port counter events
  input  wire logic                       tx_busy_dec,
  input  wire logic                       tx_full_dec,
  input  wire logic                       rx_busy_inc,
  input  wire logic                       rx_full_inc,
  // Counter values
  output      logic [bru_pkg::CNT_W-1:0]  tx_busy_counter,
  output      logic [bru_pkg::CNT_W-1:0]  tx_full_counter,
  output      logic [bru_pkg::CNT_W-1:0]  rx_busy_counter,
  output      logic [bru_pkg::CNT_W-1:0]  rx_full_counter
);
  import bru_pkg::*;

  // Saturating step so a runaway handshake cannot wrap a counter
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] cnt,
                                                input logic inc,
                                                input logic dec);
    logic [CNT_W-1:0] res;
    res = cnt;
    if (inc && !dec && (cnt != CNT_MAX)) begin
      res = cnt + CNT_ONE;
    end else if (dec && !inc && (cnt != CNT_MIN)) begin
      res = cnt - CNT_ONE;
    end
    return res;
  endfunction

  bru_dec_if dec_bus ();

  bru_decoder u_decoder (
    .instr_word (instr_word),
    .ess_in     (ess_in),
    .dec        (dec_bus.producer)
  );

  // State
  logic [ADDR_W-1:0] link_reg;
  logic [ADDR_W-1:0] link_next;
  logic [ADDR_W-1:0] shadow_reg;
  logic [ADDR_W-1:0] shadow_next;
  bru_shd_state_type shd_state_reg;
  bru_shd_state_type shd_state_next;
  logic [CNT_W-1:0]  txb_reg;
  logic [CNT_W-1:0]  txf_reg;
  logic [CNT_W-1:0]  rxb_reg;
  logic [CNT_W-1:0]  rxf_reg;
  logic              br_valid_reg;
  logic              br_taken_reg;
  logic [ADDR_W-1:0] br_target_reg;
  logic              br_null_reg;
  logic              br_illegal_reg;
  logic              wr_pend_reg;
  logic [7:0]        wr_ofs_reg;
  logic [31:0]       hrdata_reg;

  // Instruction acceptance
  wire logic shd_pending = (shd_state_reg == SHD_WAIT);
  wire logic is_shd_br   = dec_bus.is_branch && (dec_bus.src == SRC_SHADOW);
  wire logic stall_now   = instr_valid && is_shd_br && shd_pending;
  wire logic accept      = instr_valid && dec_bus.is_branch && !stall_now;
  wire logic accept_bad  = instr_valid && dec_bus.illegal;
  wire logic take_now    = accept && dec_bus.taken;
  wire logic link_now    = take_now && dec_bus.link;

  // Target selection
  wire logic [ADDR_W-1:0] sel_target =
    (dec_bus.src == SRC_SHADOW) ? shadow_reg :
    (dec_bus.src == SRC_LINK)   ? link_reg   :
                                  dec_bus.imm;
  // Not taken: flow goes to the word after the committed slot
  wire logic [ADDR_W-1:0] seq_target = instr_addr + LINK_STEP;

  // Counter operation ignores the condition outcome
  wire logic cso_rxb = accept && (dec_bus.cso == CSO_DEC_RXB);
  wire logic cso_rxf = accept && (dec_bus.cso == CSO_DEC_RXF);
  wire logic cso_txb = accept && (dec_bus.cso == CSO_INC_TXB);
  wire logic cso_txf = accept && (dec_bus.cso == CSO_INC_TXF);

  // Shadow load from fast memory
  wire logic ldfm_start = ldfm_valid && ldfm_link_option &&
                          (ldfm_halfword != HALF_ZERO);
  wire logic fm_capture = shd_pending && fm_first_valid;

  // AHB-Lite decode
  wire logic       ahb_act   = hsel && hready && htrans[HTRANS_ACT_BIT];
  wire logic       ahb_wr    = ahb_act && hwrite;
  wire logic       ahb_rd    = ahb_act && !hwrite;
  wire logic [7:0] ahb_ofs   = haddr[AHB_DEC_W-1:0];
  wire logic       sw_link   = wr_pend_reg && (wr_ofs_reg == REG_LINK_OFS);
  wire logic       sw_shadow = wr_pend_reg && (wr_ofs_reg == REG_SHADOW_OFS) &&
                               (shd_state_reg == SHD_LOADED);

  wire logic [31:0] rd_link   = {20'h0_0000, link_reg};
  wire logic [31:0] rd_shadow = {20'h0_0000, shadow_reg};
  wire logic [31:0] rd_count  = {rxf_reg, rxb_reg, txf_reg, txb_reg};
  wire logic [31:0] rd_status = {30'h0000_0000, (shd_state_reg == SHD_LOADED),
                                 shd_pending};
  wire logic [31:0] rd_mux =
    (ahb_ofs == REG_LINK_OFS)   ? rd_link   :
    (ahb_ofs == REG_SHADOW_OFS) ? rd_shadow :
    (ahb_ofs == REG_COUNT_OFS)  ? rd_count  :
    (ahb_ofs == REG_STATUS_OFS) ? rd_status : WORD_ZERO;

  // Branch link beats a software write landing in the same cycle
  assign link_next = link_now ? seq_target :
                     sw_link  ? hwdata[ADDR_W-1:0] : link_reg;

  // Fast memory capture beats a software write
  assign shadow_next = fm_capture ? fm_first_word[ADDR_W-1:0] :
                       sw_shadow  ? hwdata[ADDR_W-1:0] : shadow_reg;

  always_comb begin
    case (shd_state_reg)
      SHD_EMPTY:  shd_state_next = ldfm_start ? SHD_WAIT : SHD_EMPTY;
      SHD_WAIT:   shd_state_next = ldfm_start ? SHD_WAIT :
                                   (fm_first_valid ? SHD_LOADED : SHD_WAIT);
      SHD_LOADED: shd_state_next = ldfm_start ? SHD_WAIT : SHD_LOADED;
      default:    shd_state_next = SHD_EMPTY;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_reg      <= ADDR_ZERO;
      shadow_reg    <= ADDR_ZERO;
      shd_state_reg <= SHD_EMPTY;
    end else begin
      link_reg      <= link_next;
      shadow_reg    <= shadow_next;
      shd_state_reg <= shd_state_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txb_reg <= CNT_MIN;
      txf_reg <= CNT_MIN;
      rxb_reg <= CNT_MIN;
      rxf_reg <= CNT_MIN;
    end else begin
      txb_reg <= cnt_step(txb_reg, cso_txb, tx_busy_dec);
      txf_reg <= cnt_step(txf_reg, cso_txf, tx_full_dec);
      rxb_reg <= cnt_step(rxb_reg, rx_busy_inc, cso_rxb);
      rxf_reg <= cnt_step(rxf_reg, rx_full_inc, cso_rxf);
    end
  end

  // Branch result, one cycle after the instruction is accepted, taken or not
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      br_valid_reg   <= 1'b0;
      br_taken_reg   <= 1'b0;
      br_target_reg  <= ADDR_ZERO;
      br_null_reg    <= 1'b0;
      br_illegal_reg <= 1'b0;
    end else begin
      br_valid_reg   <= accept;
      br_taken_reg   <= take_now;
      br_target_reg  <= take_now ? sel_target : seq_target;
      br_null_reg    <= accept && dec_bus.nullify;
      br_illegal_reg <= accept_bad;
    end
  end

  // Reads are answered with zero wait; writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= REG_LINK_OFS;
      hrdata_reg  <= WORD_ZERO;
    end else begin
      wr_pend_reg <= ahb_wr;
      wr_ofs_reg  <= ahb_ofs;
      if (ahb_rd) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  assign hreadyout       = 1'b1;
  assign hresp           = HRESP_OKAY;
  assign hrdata          = hrdata_reg;
  assign instr_stall     = stall_now;
  assign br_valid        = br_valid_reg;
  assign br_taken        = br_taken_reg;
  assign br_target       = br_target_reg;
  assign br_slot_nullify = br_null_reg;
  assign br_illegal      = br_illegal_reg;
  assign tx_busy_counter = txb_reg;
  assign tx_full_counter = txf_reg;
  assign rx_busy_counter = rxb_reg;
  assign rx_full_counter = rxf_reg;

  // hsize is accepted but only full-word single transfers are expected
  wire logic unused_ok = &{1'b0, hsize, haddr[31:AHB_DEC_W]};
endmodule

// ---- test/bru_fastmem_model.sv ----
// Fast memory model that returns the first descriptor word after a linked load
`timescale 1ns/100ps
module bru_fastmem_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Load request, answer latency and descriptor word
  input  wire logic        ldfm_valid,
  input  wire logic        ldfm_link_option,
  input  wire logic [7:0]  ldfm_halfword,
  input  wire logic [3:0]  lat,
  input  wire logic [31:0] word,
  // First word return
  output      logic        fm_first_valid,
  output      logic [31:0] fm_first_word
);
  logic [3:0] cnt_reg;
  wire  logic req = ldfm_valid && ldfm_link_option && (ldfm_halfword != 8'h00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 4'h0;
      fm_first_valid <= 1'b0;
      fm_first_word <= 32'h0000_0000;
    end else begin
      cnt_reg <= req ? lat : (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
      fm_first_valid <= (cnt_reg == 4'h1);
      // Outside the pulse the word flips, so a stale value never passes
      fm_first_word <= (cnt_reg == 4'h1) ? word : ~fm_first_word;
    end
  end
endmodule

// ---- test/bru_branch_unit_sva.sv ----
// Concurrent checks on the branch unit's pipeline and fast-memory ports
`timescale 1ns/100ps
module bru_branch_unit_sva (
  // Clock and reset
  input wire logic                       hclk,
  input wire logic                       hresetn,
  // Pipeline side
  input wire logic                       instr_valid,
  input wire logic [bru_pkg::INSTR_W-1:0] instr_word,
  input wire logic [bru_pkg::ADDR_W-1:0] instr_addr,
  input wire logic [bru_pkg::ESS_N-1:0]  ess_in,
  input wire logic                       instr_stall,
  input wire logic                       br_valid,
  input wire logic                       br_taken,
  input wire logic [bru_pkg::ADDR_W-1:0] br_target,
  input wire logic                       br_slot_nullify,
  input wire logic                       br_illegal,
  // Fast memory and counters
  input wire logic                       ldfm_valid,
  input wire logic                       ldfm_link_option,
  input wire logic [bru_pkg::HALF_W-1:0] ldfm_halfword,
  input wire logic                       rx_busy_inc,
  input wire logic [bru_pkg::CNT_W-1:0]  rx_busy_counter
);
  import bru_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire logic [5:0] opc = instr_word[OP_HI:OP_LO];
  wire logic [3:0] sel = instr_word[ESS_HI:ESS_LO];
  wire logic is_br = instr_valid && (opc <= OPC_SHD_LINK);
  wire logic low_ok = (opc[5:1] == 5'h00) || (instr_word[WADR_HI:WADR_LO] == LOW_ZERO);
  wire logic acc = is_br && low_ok && !instr_stall;
  wire logic met = (sel == ESS_NONE) || (ess_in[sel] == instr_word[POL_BIT]);
  wire logic nul = instr_word[COND_BIT] && ((sel == ESS_NONE) || !met);
  wire logic is_shd = instr_valid && (opc[5:1] == 5'h02);

  sequence s_load;
    ldfm_valid && ldfm_link_option && (ldfm_halfword != HALF_ZERO);
  endsequence
  sequence s_acc;
    acc;
  endsequence

  chk_accept_pulse: assert property (s_acc |=> br_valid)
    else $error("accepted branch gave no result pulse");
  chk_illegal_form: assert property (is_br && !low_ok && !instr_stall |=>
    br_illegal && !br_valid)
    else $error("bad non-immediate form not flagged");
  chk_imm_target: assert property (acc && opc[5:1] == 5'h00 && met |=>
    br_taken && br_target == $past(instr_word[WADR_HI:WADR_LO]))
    else $error("immediate target wrong");
  chk_cond_taken: assert property (acc && sel != ESS_NONE |=> br_taken == $past(met))
    else $error("condition outcome wrong");
  chk_miss_target: assert property (acc && !met |=>
    br_target == $past(instr_addr) + LINK_STEP)
    else $error("not taken target wrong");
  chk_slot_nullify: assert property (s_acc |=> br_slot_nullify == $past(nul))
    else $error("slot nullify wrong");
  chk_shadow_stall: assert property (s_load ##1 is_shd |-> instr_stall)
    else $error("shadow branch not held during load");
  chk_stall_cause: assert property (instr_stall |-> is_shd)
    else $error("stall without shadow branch");
  chk_rxb_decrement: assert property (acc && rx_busy_counter != CNT_MIN &&
    instr_word[CSO_HI:CSO_LO] == CSO_CODE_DEC_RXB && !rx_busy_inc |=>
    rx_busy_counter == $past(rx_busy_counter) - CNT_ONE)
    else $error("receive busy counter not decremented");
endmodule

bind bru_branch_unit bru_branch_unit_sva i_sva (.hclk, .hresetn, .instr_valid, .instr_word,
  .instr_addr, .ess_in, .instr_stall, .br_valid, .br_taken, .br_target, .br_slot_nullify,
  .br_illegal, .ldfm_valid, .ldfm_link_option, .ldfm_halfword, .rx_busy_inc, .rx_busy_counter);

// ---- test/bru_branch_unit_tb_top.sv ----
// Self-checking bench for the branch unit: bus, branches, shadow load, counters
`timescale 1ns/100ps
module bru_branch_unit_tb_top;
  import bru_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, hready, hreadyout;
  logic        instr_valid, instr_stall, ldfm_valid, ldfm_link_option, fm_first_valid;
  logic        br_valid, br_taken, br_slot_nullify, br_illegal;
  logic        tx_busy_dec, tx_full_dec, rx_busy_inc, rx_full_inc;
  logic [1:0]  htrans, hresp;
  logic [3:0]  lat;
  logic [7:0]  ldfm_halfword, tx_busy_counter, tx_full_counter, rx_busy_counter, rx_full_counter;
  logic [11:0] instr_addr, br_target;
  logic [15:0] ess_in;
  logic [31:0] haddr, hwdata, hrdata, instr_word, fm_first_word, word;
  int          mismatches = 0, checks = 0, stalls = 0;

  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;
  wire logic [31:0] cnt_all = {rx_full_counter, rx_busy_counter,
                               tx_full_counter, tx_busy_counter};

  bru_branch_unit i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .instr_valid, .instr_word, .instr_addr, .ess_in,
    .instr_stall, .br_valid, .br_taken, .br_target, .br_slot_nullify, .br_illegal, .ldfm_valid,
    .ldfm_link_option, .ldfm_halfword, .fm_first_valid, .fm_first_word, .tx_busy_dec,
    .tx_full_dec, .rx_busy_inc, .rx_full_inc, .tx_busy_counter, .tx_full_counter,
    .rx_busy_counter, .rx_full_counter);
  bru_fastmem_model i_fm (.hclk, .hresetn, .ldfm_valid, .ldfm_link_option, .ldfm_halfword, .lat,
    .word, .fm_first_valid, .fm_first_word);

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      cmp(32'h0, 32'h1);
      conclude();
    end
  endtask
  // Master holds each phase until hready is sampled high
  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, exp);
    logic [31:0] q;
    ahb(1'b0, a, WORD_ZERO, q);
    cmp(q, exp);
    cmp({30'h0, hresp}, {30'h0, HRESP_OKAY});
  endtask
  function automatic logic [31:0] bw(logic [5:0] op, logic [3:0] s, logic p, c, logic [7:0] o,
                                      logic [11:0] t);
    return {op, s, p, c, o, t};
  endfunction
  // Presents a branch, retries while held, then judges the result pulse
  task automatic br(input logic [31:0] w, input logic [11:0] a, input logic ok, tk,
                    input logic [11:0] tg, input logic nl);
    int n = 0;
    logic st;
    instr_valid <= 1'b1; instr_word <= w; instr_addr <= a;
    do begin
      @(negedge hclk);
      st = instr_stall;
      if (st === 1'b1) stalls++;
      @(posedge hclk);
      n++;
    end while (st !== 1'b0 && n < 40);
    if (st !== 1'b0) begin
      cmp(32'h0, 32'h1);
      conclude();
    end
    instr_valid <= 1'b0;
    @(negedge hclk);
    cmp({16'h0, br_valid, br_illegal, br_taken, br_slot_nullify, ok ? br_target : 12'h0},
        ok ? {16'h0, 2'b10, tk, nl, tg} : {16'h0, 4'b0100, 12'h0});
    @(posedge hclk);
  endtask
  task automatic ld(input logic lo, input logic [7:0] hw);
    ldfm_valid <= 1'b1; ldfm_link_option <= lo; ldfm_halfword <= hw;
    @(posedge hclk);
    ldfm_valid <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic ev(input logic [3:0] v);
    {rx_full_inc, rx_busy_inc, tx_full_dec, tx_busy_dec} <= v;
    @(posedge hclk);
    {rx_full_inc, rx_busy_inc, tx_full_dec, tx_busy_dec} <= 4'h0;
    @(posedge hclk);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 5; i++) rd(32'(i * 4), WORD_ZERO);
    wr(32'h10, 32'hFFFF_FFFF);
    rd(32'h10, WORD_ZERO);
    $display("test regs done");
  endtask
  task automatic t_flow;
    ess_in <= 16'h0002;
    br(bw(OPC_IMM, 4'h0, 0, 0, 8'h00, 12'h045), 12'h011, 1, 1, 12'h045, 0);
    br(bw(OPC_IMM, 4'h1, 1, 0, 8'h00, 12'h045), 12'h011, 1, 1, 12'h045, 0);
    br(bw(OPC_IMM, 4'h1, 0, 1, 8'h00, 12'h045), 12'h011, 1, 0, 12'h013, 1);
    br(bw(OPC_IMM, 4'h1, 0, 0, 8'h00, 12'h045), 12'h011, 1, 0, 12'h013, 0);
    br(bw(OPC_IMM, 4'h0, 0, 1, 8'h00, 12'h045), 12'h011, 1, 1, 12'h045, 1);
    br(bw(OPC_IMM, 4'hF, 0, 0, 8'h00, 12'hFFF), 12'hFFE, 1, 1, 12'hFFF, 0);
    $display("test flow done");
  endtask
  task automatic t_link;
    br(bw(OPC_IMM_LINK, 4'h0, 0, 0, 8'h00, 12'h045), 12'h011, 1, 1, 12'h045, 0);
    rd(REG_LINK_OFS, 32'h013);
    br(bw(OPC_IMM_LINK, 4'h1, 0, 0, 8'h00, 12'h077), 12'h020, 1, 0, 12'h022, 0);
    rd(REG_LINK_OFS, 32'h013);
    br(bw(OPC_REG, 4'h0, 0, 0, 8'h00, 12'h000), 12'h046, 1, 1, 12'h013, 0);
    br(bw(OPC_REG_LINK, 4'h0, 0, 1, 8'h00, 12'h000), 12'h030, 1, 1, 12'h013, 1);
    rd(REG_LINK_OFS, 32'h032);
    wr(REG_LINK_OFS, 32'h7FF);
    br(bw(OPC_REG, 4'h0, 0, 0, 8'h00, 12'h000), 12'h100, 1, 1, 12'h7FF, 0);
    br(bw(OPC_REG_LINK, 4'h0, 0, 0, 8'h00, 12'h001), 12'h200, 0, 0, 12'h000, 0);
    rd(REG_LINK_OFS, 32'h7FF);
    $display("test link done");
  endtask
  task automatic t_shadow;
    int s0;
    br(bw(OPC_SHD, 4'h0, 0, 0, 8'h00, 12'h000), 12'h040, 1, 1, 12'h000, 0);
    wr(REG_SHADOW_OFS, 32'h123);
    rd(REG_SHADOW_OFS, WORD_ZERO);
    ld(1'b0, 8'h05);
    ld(1'b1, 8'h00);
    rd(REG_STATUS_OFS, WORD_ZERO);
    lat <= 4'h6; word <= 32'hA5A5_0ABC;
    ld(1'b1, 8'h05);
    rd(REG_STATUS_OFS, 32'h1);
    s0 = stalls;
    br(bw(OPC_SHD, 4'h0, 0, 0, 8'h00, 12'h000), 12'h041, 1, 1, 12'hABC, 0);
    cmp(32'(stalls > s0), 32'h1);
    rd(REG_STATUS_OFS, 32'h2);
    wr(REG_SHADOW_OFS, 32'h123);
    rd(REG_SHADOW_OFS, 32'h123);
    br(bw(OPC_SHD_LINK, 4'h0, 0, 0, 8'h00, 12'h000), 12'h050, 1, 1, 12'h123, 0);
    rd(REG_LINK_OFS, 32'h052);
    lat <= 4'h1; word <= 32'h0000_0321;
    // Branch follows the load at once, so it meets the pending fetch
    ldfm_valid <= 1'b1; ldfm_link_option <= 1'b1; ldfm_halfword <= 8'hFF;
    @(posedge hclk);
    ldfm_valid <= 1'b0;
    br(bw(OPC_SHD, 4'h0, 0, 0, 8'h00, 12'h000), 12'h060, 1, 1, 12'h321, 0);
    $display("test shadow done");
  endtask
  task automatic t_count;
    logic [7:0] codes [4] = '{CSO_CODE_DEC_RXB, CSO_CODE_DEC_RXF, CSO_CODE_INC_TXB,
                              CSO_CODE_INC_TXF};
    ev(4'hC);
    ev(4'h4);
    for (int i = 0; i < 4; i++)
      br(bw(OPC_IMM, 4'h1, 0, 0, codes[i], 12'h045), 12'h011, 1, 0, 12'h013, 0);
    cmp(cnt_all, 32'h0001_0101);
    rd(REG_COUNT_OFS, 32'h0001_0101);
    ev(4'h1);
    br(bw(OPC_IMM, 4'h0, 0, 0, CSO_CODE_DEC_RXF, 12'h045), 12'h011, 1, 1, 12'h045, 0);
    cmp(cnt_all, 32'h0001_0100);
    $display("test count done");
  endtask

  initial begin
    {hsel, hwrite, instr_valid, ldfm_valid, ldfm_link_option} = 5'h0;
    {tx_busy_dec, tx_full_dec, rx_busy_inc, rx_full_inc} = 4'h0;
    htrans = 2'h0; lat = 4'h1; ldfm_halfword = 8'h00; instr_addr = 12'h000; ess_in = 16'h0;
    haddr = 32'h0; hwdata = 32'h0; instr_word = 32'hFFFF_FFFF; word = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_flow();
    t_link();
    t_shadow();
    t_count();
    conclude();
  end
endmodule
